// ---- hw/t16cc_defines.svh ----
// register indices, field positions, reset values of the 16-bit timer
`ifndef T16CC_DEFINES_SVH
`define T16CC_DEFINES_SVH

// ==========================================================================
// register indices (byte address on the bus is four times the index)
`define T16CC_IDX_RUN      10'h180
`define T16CC_IDX_MODE     10'h182
`define T16CC_IDX_FFCTRL   10'h183
`define T16CC_IDX_CMPA_L   10'h188
`define T16CC_IDX_CMPA_H   10'h189
`define T16CC_IDX_CMPB_L   10'h18A
`define T16CC_IDX_CMPB_H   10'h18B
`define T16CC_IDX_CAPA_L   10'h18C
`define T16CC_IDX_CAPA_H   10'h18D
`define T16CC_IDX_CAPB_L   10'h18E
`define T16CC_IDX_CAPB_H   10'h18F

// ==========================================================================
// field positions
`define T16CC_RUN_BUFEN    7
`define T16CC_RUN_PRUN     2
`define T16CC_RUN_CRUN     0
`define T16CC_MODE_CLK     0
`define T16CC_MODE_CLE     2
`define T16CC_MODE_CPM     3
`define T16CC_MODE_SWCAP   5
`define T16CC_FF_A_CTL     0
`define T16CC_FF_TRIG      2
`define T16CC_FF_B_CTL     6

// ==========================================================================
// reset values
`define T16CC_RST_RUN      8'h00
`define T16CC_RST_MODE     8'h00
`define T16CC_RST_FFCTRL   8'h20

// ==========================================================================
// divider figures
`define T16CC_BASE_DIV_M1  2'h3
`define T16CC_TAP8_MASK    5'h01
`define T16CC_TAP32_MASK   5'h07
`define T16CC_TAP128_MASK  5'h1F
`define T16CC_CNT_MAX      16'hFFFF

`endif

// ---- hw/t16cc_pkg.sv ----
// types of the 16-bit timer with capture and compare
package t16cc_pkg;

    typedef enum logic [1:0] {
        T16CC_CLK_EXT  = 2'h0,
        T16CC_CLK_T8   = 2'h1,
        T16CC_CLK_T32  = 2'h2,
        T16CC_CLK_T128 = 2'h3
    } t16cc_clk_e;

    typedef enum logic [1:0] {
        T16CC_CAP_OFF      = 2'h0,
        T16CC_CAP_RISEFALL = 2'h1,
        T16CC_CAP_RISE     = 2'h2,
        T16CC_CAP_MATCHB   = 2'h3
    } t16cc_cap_e;

    typedef struct packed {
        logic [3:0]  gear_cnt;
        logic [1:0]  base_cnt;
        logic [4:0]  presc;
        logic [15:0] cnt;
        logic        buf_en;
        logic        presc_run;
        logic        cnt_run;
        t16cc_clk_e  clk_sel;
        logic        clr_en;
        t16cc_cap_e  cap_mode;
        logic [3:0]  trig_en;
        logic [15:0] cmp_a;
        logic [15:0] cmp_a_buf;
        logic [15:0] cmp_b;
        logic [15:0] cap_a;
        logic [15:0] cap_b;
        logic [7:0]  cap_a_hi;
        logic [7:0]  cap_b_hi;
        logic        ff_a;
        logic        ff_b;
        logic        evt_prev;
        logic        irq_a;
        logic        irq_b;
        logic        irq_ovf;
        logic        ack;
        logic [31:0] rdata;
    } t16cc_state_s;

endpackage

// ---- hw/t16cc_top.sv ----
// 16-bit timer with prescaler, compare, capture and toggle flip-flops
//
// Function
// - a 5-bit prescaler generates the timer source clocks
// - prescaler base clock is the gear-selected clock divided by four
// - run bit 1 counts the prescaler; 0 clears and halts it
// - taps are gear clock divided by 8, 32 and 128
// - up-counter is 16-bit, one step per selected clock pulse
// - clock is one of three taps or event pin; run bit counts or clears
// - with clear enabled the counter clears on match with compare b
// - with clear disabled the counter runs freely over 16 bits
// - counter overflow raises the overflow request
// - buffer enable bit 0 disables, 1 enables double buffer; resets 0
// - with buffering, match with compare b loads buffer into compare a
// - compare a writes hit both copies unbuffered, buffer only buffered
// - counter latches into capture registers as capture timing selects
// - writing 0 to soft capture bit captures into capture a
// - two comparators raise compare requests on equality
// - flip-flop a toggles once in any cycle with one or more enabled capture or match triggers
// - control field 00 inverts, 01 sets, 10 clears, 11 holds
// - flip-flop values drive the two timer output pins
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "t16cc_defines.svh"

module t16cc_top
    import t16cc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    input  wire logic [2:0]  clock_gear_select,
    input  wire logic        event_input_pin,
    output var  logic        timer_output_a,
    output var  logic        timer_output_b,
    output var  logic        compare_a_irq,
    output var  logic        compare_b_irq,
    output var  logic        overflow_irq
);

    t16cc_state_s s_reg;
    t16cc_state_s s_next;
    localparam logic [7:0] RST_RUN_V = `T16CC_RST_RUN;
    localparam logic [7:0] RST_FF_V  = `T16CC_RST_FFCTRL;

    logic [9:0]  idx;
    logic        req;
    logic        wr;
    logic        rd;
    logic [7:0]  wbyte;
    logic [3:0]  gear_lim;
    logic        gear_tick;
    logic        base_tick;
    logic        presc_tick;
    logic        tap8;
    logic        tap32;
    logic        tap128;
    logic        evt_rise;
    logic        evt_fall;
    logic        count_tick;
    logic        match_a;
    logic        match_b;
    logic        ovf;
    logic        soft_cap;
    logic        cap_a_ev;
    logic        cap_b_ev;
    logic        toggle_a;
    logic [7:0]  rbyte;

    function automatic logic ff_apply(input logic cur, input logic [1:0] c);
        case (c)
            2'h0:    ff_apply = ~cur;
            2'h1:    ff_apply = 1'b1;
            2'h2:    ff_apply = 1'b0;
            default: ff_apply = cur;
        endcase
    endfunction

    // ======================================================================
    // bus decode: one wait cycle, ack for one cycle, unmapped reads zero
    assign idx   = wb_adr_i[11:2];
    assign req   = wb_cyc_i & wb_stb_i & ~s_reg.ack;
    assign wr    = req & wb_we_i & wb_sel_i[0];
    assign rd    = req & ~wb_we_i;
    assign wbyte = wb_dat_i[7:0];

    // ======================================================================
    // clock gear and prescaler
    always_comb begin
        case (clock_gear_select)
            3'h0:    gear_lim = 4'h0;
            3'h1:    gear_lim = 4'h1;
            3'h2:    gear_lim = 4'h3;
            3'h3:    gear_lim = 4'h7;
            default: gear_lim = 4'hF;
        endcase
    end

    assign gear_tick  = (s_reg.gear_cnt >= gear_lim);
    assign base_tick  = gear_tick & (s_reg.base_cnt == `T16CC_BASE_DIV_M1);
    assign presc_tick = base_tick & s_reg.presc_run;
    assign tap8   = presc_tick &
                    ((s_reg.presc & `T16CC_TAP8_MASK) == `T16CC_TAP8_MASK);
    assign tap32  = presc_tick &
                    ((s_reg.presc & `T16CC_TAP32_MASK) == `T16CC_TAP32_MASK);
    assign tap128 = presc_tick &
                    ((s_reg.presc & `T16CC_TAP128_MASK) == `T16CC_TAP128_MASK);

    // ======================================================================
    // counter clock, comparators and capture events
    assign evt_rise = event_input_pin & ~s_reg.evt_prev;
    assign evt_fall = ~event_input_pin & s_reg.evt_prev;

    always_comb begin
        case (s_reg.clk_sel)
            T16CC_CLK_EXT:  count_tick = evt_rise & s_reg.presc_run;
            T16CC_CLK_T8:   count_tick = tap8;
            T16CC_CLK_T32:  count_tick = tap32;
            T16CC_CLK_T128: count_tick = tap128;
            default:        count_tick = 1'b0;
        endcase
        count_tick = count_tick & s_reg.cnt_run;
    end

    assign match_a = count_tick & (s_reg.cnt == s_reg.cmp_a);
    assign match_b = count_tick & (s_reg.cnt == s_reg.cmp_b);
    assign ovf = count_tick & (s_reg.cnt == `T16CC_CNT_MAX) &
                 ~(s_reg.clr_en & match_b);

    assign soft_cap = wr & (idx == `T16CC_IDX_MODE) &
                      ~wbyte[`T16CC_MODE_SWCAP];

    always_comb begin
        case (s_reg.cap_mode)
            T16CC_CAP_RISEFALL: begin
                cap_a_ev = evt_rise;
                cap_b_ev = evt_fall;
            end
            T16CC_CAP_RISE: begin
                cap_a_ev = evt_rise;
                cap_b_ev = 1'b0;
            end
            T16CC_CAP_MATCHB: begin
                cap_a_ev = 1'b0;
                cap_b_ev = match_b;
            end
            default: begin
                cap_a_ev = 1'b0;
                cap_b_ev = 1'b0;
            end
        endcase
        cap_a_ev = cap_a_ev | soft_cap;
    end

    assign toggle_a = |({cap_b_ev, cap_a_ev, match_b, match_a} &
                        s_reg.trig_en);

    // ======================================================================
    // read mux
    always_comb begin
        case (idx)
            `T16CC_IDX_RUN:    rbyte = {s_reg.buf_en, 4'h0, s_reg.presc_run,
                                        1'b0, s_reg.cnt_run};
            `T16CC_IDX_MODE:   rbyte = {2'h0, 1'b1, s_reg.cap_mode,
                                        s_reg.clr_en, s_reg.clk_sel};
            `T16CC_IDX_FFCTRL: rbyte = {2'h3, s_reg.trig_en, 2'h3};
            `T16CC_IDX_CMPA_L: rbyte = s_reg.cmp_a[7:0];
            `T16CC_IDX_CMPA_H: rbyte = s_reg.cmp_a[15:8];
            `T16CC_IDX_CMPB_L: rbyte = s_reg.cmp_b[7:0];
            `T16CC_IDX_CMPB_H: rbyte = s_reg.cmp_b[15:8];
            `T16CC_IDX_CAPA_L: rbyte = s_reg.cap_a[7:0];
            `T16CC_IDX_CAPA_H: rbyte = s_reg.cap_a_hi;
            `T16CC_IDX_CAPB_L: rbyte = s_reg.cap_b[7:0];
            `T16CC_IDX_CAPB_H: rbyte = s_reg.cap_b_hi;
            default:           rbyte = 8'h00;
        endcase
    end

    // ======================================================================
    // next state
    always_comb begin
        s_next = s_reg;
        s_next.evt_prev = event_input_pin;
        s_next.gear_cnt = gear_tick ? 4'h0 : s_reg.gear_cnt + 4'h1;

        if (!s_reg.presc_run) begin
            s_next.base_cnt = 2'h0;
            s_next.presc    = 5'h00;
        end else begin
            if (gear_tick)
                s_next.base_cnt = s_reg.base_cnt + 2'h1;
            if (base_tick)
                s_next.presc = s_reg.presc + 5'h01;
        end

        if (!s_reg.cnt_run) begin
            s_next.cnt = 16'h0000;
        end else if (count_tick) begin
            if (s_reg.clr_en && s_reg.cnt == s_reg.cmp_b)
                s_next.cnt = 16'h0000;
            else
                s_next.cnt = s_reg.cnt + 16'h0001;
        end

        if (s_reg.buf_en && match_b)
            s_next.cmp_a = s_reg.cmp_a_buf;

        if (cap_a_ev)
            s_next.cap_a = s_reg.cnt;
        if (cap_b_ev)
            s_next.cap_b = s_reg.cnt;
        if (toggle_a)
            s_next.ff_a = ~s_reg.ff_a;

        s_next.irq_a   = match_a;
        s_next.irq_b   = match_b;
        s_next.irq_ovf = ovf;

        s_next.ack = req;
        if (rd) begin
            s_next.rdata = {24'h000000, rbyte};
            // low byte read freezes high byte for a coherent pair
            if (idx == `T16CC_IDX_CAPA_L)
                s_next.cap_a_hi = s_reg.cap_a[15:8];
            if (idx == `T16CC_IDX_CAPB_L)
                s_next.cap_b_hi = s_reg.cap_b[15:8];
        end else if (req) begin
            s_next.rdata = 32'h00000000;
        end

        if (wr) begin
            case (idx)
                `T16CC_IDX_RUN: begin
                    s_next.buf_en    = wbyte[`T16CC_RUN_BUFEN];
                    s_next.presc_run = wbyte[`T16CC_RUN_PRUN];
                    s_next.cnt_run   = wbyte[`T16CC_RUN_CRUN];
                end
                `T16CC_IDX_MODE: begin
                    s_next.clk_sel  = t16cc_clk_e'(wbyte[1:0]);
                    s_next.clr_en   = wbyte[`T16CC_MODE_CLE];
                    s_next.cap_mode = t16cc_cap_e'(wbyte[4:3]);
                end
                `T16CC_IDX_FFCTRL: begin
                    s_next.trig_en = wbyte[5:2];
                    // software control is applied after a trigger toggle in the same cycle
                    s_next.ff_a = ff_apply(s_next.ff_a, wbyte[1:0]);
                    s_next.ff_b = ff_apply(s_reg.ff_b, wbyte[7:6]);
                end
                `T16CC_IDX_CMPA_L: begin
                    s_next.cmp_a_buf[7:0] = wbyte;
                    if (!s_reg.buf_en)
                        s_next.cmp_a[7:0] = wbyte;
                end
                `T16CC_IDX_CMPA_H: begin
                    s_next.cmp_a_buf[15:8] = wbyte;
                    if (!s_reg.buf_en)
                        s_next.cmp_a[15:8] = wbyte;
                end
                `T16CC_IDX_CMPB_L: s_next.cmp_b[7:0]  = wbyte;
                `T16CC_IDX_CMPB_H: s_next.cmp_b[15:8] = wbyte;
                default: ;
            endcase
        end
    end

    // ======================================================================
    // state register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_reg           <= '0;
            s_reg.buf_en    <= RST_RUN_V[`T16CC_RUN_BUFEN];
            s_reg.trig_en   <= RST_FF_V[`T16CC_FF_TRIG +: 4];
        end else begin
            s_reg <= s_next;
        end
    end

    // ======================================================================
    // outputs, all straight from the state register
    // flip-flops drive the pins
    assign timer_output_a = s_reg.ff_a;
    assign timer_output_b = s_reg.ff_b;
    assign compare_a_irq  = s_reg.irq_a;
    assign compare_b_irq  = s_reg.irq_b;
    assign overflow_irq   = s_reg.irq_ovf;
    assign wb_ack_o       = s_reg.ack;
    assign wb_dat_o       = s_reg.rdata;

    // ======================================================================
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_presc_wrap: assert property (
        presc_tick && s_reg.presc == 5'h1F |=> s_reg.presc == 5'h00)
        else $error("prescaler did not wrap at 5 bits");

    a_presc_halt: assert property (
        $fell(s_reg.presc_run) |=> (s_reg.presc == 5'h00) [*3])
        else $error("stopped prescaler not held at zero");

    a_stop_clear: assert property (
        !s_reg.cnt_run ##1 !s_reg.cnt_run |-> s_reg.cnt == 16'h0000)
        else $error("stopped counter not cleared");

    a_clear_match: assert property (
        count_tick && s_reg.clr_en && s_reg.cnt == s_reg.cmp_b
        |=> s_reg.cnt == 16'h0000)
        else $error("counter not cleared on compare b match");

    a_free_run: assert property (
        count_tick && !s_reg.clr_en
        |=> s_reg.cnt == $past(s_reg.cnt) + 16'h0001)
        else $error("free-running counter did not step by one");

    a_overflow_irq: assert property (
        count_tick && !s_reg.clr_en && s_reg.cnt == 16'hFFFF
        |=> overflow_irq ##1 !overflow_irq)
        else $error("overflow request missing or not a pulse");

    a_buffer_load: assert property (
        s_reg.buf_en && match_b && !wr
        |=> s_reg.cmp_a == $past(s_reg.cmp_a_buf))
        else $error("buffer not moved into compare a");

    a_write_both: assert property (
        wr && idx == `T16CC_IDX_CMPA_L && !s_reg.buf_en
        |=> s_reg.cmp_a[7:0] == $past(wbyte) &&
            s_reg.cmp_a_buf[7:0] == $past(wbyte))
        else $error("unbuffered write did not reach both copies");

    a_soft_capture: assert property (
        soft_cap |=> s_reg.cap_a == $past(s_reg.cnt))
        else $error("software capture lost");

    a_match_irq: assert property (
        match_a |=> compare_a_irq)
        else $error("compare a request missing");

    a_ff_set: assert property (
        wr && idx == `T16CC_IDX_FFCTRL && wbyte[1:0] == 2'h1
        |=> timer_output_a)
        else $error("set command did not set flip-flop a");

    a_ff_readback: assert property (
        rd && idx == `T16CC_IDX_FFCTRL
        |=> wb_ack_o && wb_dat_o[7:6] == 2'h3 &&
            wb_dat_o[1:0] == 2'h3)
        else $error("control fields did not read as 11");

endmodule // t16cc_top

`default_nettype wire

// ---- dv/t16cc_event_src.sv ----
// event pin source standing in for the outside world
`timescale 1ns/1ps
`default_nettype none
module t16cc_event_src (
    input  wire logic ref_clk,
    output var  logic event_input_pin
);
    initial event_input_pin = 1'b0;
    // rising edges on the pin
    // each level is held two clocks so a synchroniser cannot miss it
    task automatic send(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            event_input_pin <= 1'b1;
            repeat (2) @(posedge ref_clk);
            event_input_pin <= 1'b0;
            @(posedge ref_clk);
        end
    endtask
endmodule // t16cc_event_src
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the 16-bit timer
`timescale 1ns/1ps
`default_nettype none
`include "t16cc_defines.svh"
module tb;
    localparam logic [11:0] A_RUN  = {`T16CC_IDX_RUN, 2'h0};
    localparam logic [11:0] A_MODE = {`T16CC_IDX_MODE, 2'h0};
    localparam logic [11:0] A_FF   = {`T16CC_IDX_FFCTRL, 2'h0};
    localparam logic [11:0] A_CMPA = {`T16CC_IDX_CMPA_L, 2'h0};
    localparam logic [11:0] A_CMPB = {`T16CC_IDX_CMPB_L, 2'h0};
    localparam logic [11:0] A_CAPA = {`T16CC_IDX_CAPA_L, 2'h0};
    localparam logic [11:0] A_CAPB = {`T16CC_IDX_CAPB_L, 2'h0};
    logic        ref_clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [11:0] wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        wb_ack_o, event_input_pin, timer_output_a, timer_output_b;
    logic        compare_a_irq, compare_b_irq, overflow_irq;
    logic [2:0]  clock_gear_select;
    int          n_errors, n_compared, cyc_cnt;
    t16cc_top t16cc_top_i (.ref_clk(ref_clk), .resetn(resetn),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .clock_gear_select(clock_gear_select),
        .event_input_pin(event_input_pin),
        .timer_output_a(timer_output_a), .timer_output_b(timer_output_b),
        .compare_a_irq(compare_a_irq), .compare_b_irq(compare_b_irq),
        .overflow_irq(overflow_irq));
    t16cc_event_src t16cc_event_src_i (.ref_clk(ref_clk),
        .event_input_pin(event_input_pin));
    // ==========================================================
    // clock, timeout and report
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic tally_and_finish;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ceiling is several times the expected run length
    always @(posedge ref_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 40000) begin
            n_errors++;
            $display("CHECK FAILED %0t timeout", $time);
            tally_and_finish();
        end
    end
    // ==========================================================
    // bus tasks
    task automatic chk(input logic [15:0] got, exp, input string m);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // classic cycle: request held until ack is seen at an edge
    task automatic wb(input logic we, input logic [11:0] a,
                      input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        @(posedge ref_clk);
        while (wb_ack_o !== 1'b1) @(posedge ref_clk);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] q);
        wb(1'b0, a, 8'h00, q);
    endtask
    // low byte first
    // the high byte is frozen by the low read, so the pair is coherent
    task automatic rd16(input logic [11:0] a, output logic [15:0] v);
        logic [7:0] lo, hi;
        rd(a, lo);
        rd(a + 12'h4, hi);
        v = {hi, lo};
    endtask
    task automatic period(output int n);
        while (compare_b_irq !== 1'b1) @(posedge ref_clk);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (compare_b_irq !== 1'b1);
    endtask
    // ==========================================================
    // test sequence
    logic [7:0]  q;
    logic [15:0] v;
    logic        o;
    int          n;
    logic        ovf_seen = 1'b0;
    // counter never passes its top in these tests: any pulse is false
    always @(posedge ref_clk)
        if (overflow_irq === 1'b1)
            ovf_seen <= 1'b1;
    logic [7:0]  ff_w [7] = '{8'hC1, 8'hC2, 8'hC0, 8'hC3, 8'h43, 8'h83, 8'h03};
    logic [1:0]  ff_e [7] = '{2'h2, 2'h0, 2'h2, 2'h2, 2'h3, 2'h2, 2'h3};
    logic [2:0]  p_g [5] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h4};
    logic [7:0]  p_s [5] = '{8'h1, 8'h2, 8'h3, 8'h1, 8'h1};
    logic [15:0] p_e [5] = '{16'h20, 16'h80, 16'h200, 16'h40, 16'h200};
    initial begin
        resetn = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 12'h000;
        wb_sel_i = 4'h1;
        wb_dat_i = 32'h0;
        clock_gear_select = 3'h0;
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(A_RUN, q); chk(q, 8'h00, "run reset");
        rd(A_FF, q); chk(q, 8'hE3, "ff ctrl reset");
        rd(12'h7F0, q); chk(q, 8'h00, "unmapped");
        for (int i = 0; i < 7; i++) begin
            wr(A_FF, ff_w[i]);
            chk(16'({timer_output_a, timer_output_b}), 16'(ff_e[i]), "ff");
        end
        rd(A_FF, q); chk(q, 8'hC3, "ctl reads 11");
        // taps with clear on match b: period (3+1) taps
        wr(A_CMPB, 8'h03);
        wr(A_CMPB + 12'h4, 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr(A_RUN, 8'h00);
            clock_gear_select <= p_g[i];
            wr(A_MODE, 8'h24 | p_s[i]);
            wr(A_RUN, 8'h05);
            period(n); chk(16'(n), p_e[i], "period");
        end
        // double buffer, match a trigger
        clock_gear_select <= 3'h0;
        wr(A_RUN, 8'h00);
        wr(A_CMPB, 8'h40);
        wr(A_CMPA, 8'h10);
        wr(A_CMPA + 12'h4, 8'h00);
        rd(A_CMPA, q); chk(q, 8'h10, "cmpa direct");
        wr(A_RUN, 8'h80);
        wr(A_CMPA, 8'h20);
        rd(A_CMPA, q); chk(q, 8'h10, "cmpa buffered");
        rd(A_RUN, q); chk(q, 8'h80, "buf enable");
        wr(A_FF, 8'hC7);
        wr(A_MODE, 8'h25);
        o = timer_output_a;
        wr(A_RUN, 8'h85);
        while (compare_a_irq !== 1'b1) @(posedge ref_clk);
        repeat (2) @(posedge ref_clk);
        chk(16'(timer_output_a), {15'h0, ~o}, "match a toggle");
        while (compare_b_irq !== 1'b1) @(posedge ref_clk);
        rd(A_CMPA, q); chk(q, 8'h20, "buffer moved");
        // prescaler stopped: counter must not move
        wr(A_RUN, 8'h00);
        wr(A_MODE, 8'h21);
        wr(A_RUN, 8'h01);
        repeat (100) @(posedge ref_clk);
        wr(A_MODE, 8'h01);
        rd16(A_CAPA, v); chk(v, 16'h0000, "presc halted");
        // external count, soft capture, capture trigger, free run
        wr(A_RUN, 8'h00);
        wr(A_MODE, 8'h20);
        wr(A_FF, 8'hD3);
        wr(A_RUN, 8'h05);
        t16cc_event_src_i.send(5);
        o = timer_output_a;
        wr(A_MODE, 8'h00);
        rd16(A_CAPA, v); chk(v, 16'h0005, "ext count");
        chk(16'(timer_output_a), {15'h0, ~o}, "capture toggle");
        t16cc_event_src_i.send(62);
        wr(A_MODE, 8'h00);
        rd16(A_CAPA, v); chk(v, 16'h0043, "free run");
        // capture timing: a on rise and b on fall, a on rise only, b on match
        wr(A_MODE, 8'h28);
        t16cc_event_src_i.send(1);
        rd16(A_CAPA, v); chk(v, 16'h0043, "cap a on rise");
        rd16(A_CAPB, v); chk(v, 16'h0044, "cap b on fall");
        wr(A_MODE, 8'h30);
        t16cc_event_src_i.send(1);
        rd16(A_CAPA, v); chk(v, 16'h0044, "rise only a");
        rd16(A_CAPB, v); chk(v, 16'h0044, "rise only b");
        wr(A_CMPB, 8'h46);
        wr(A_MODE, 8'h38);
        t16cc_event_src_i.send(2);
        rd16(A_CAPB, v); chk(v, 16'h0046, "cap b on match");
        chk(16'(ovf_seen), 16'h0000, "no false overflow");
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
